// ### core/msp_lock.sv
// Purpose: Sector lock flags, written only from the programming port
// Assumes: Programmer strobe is synchronous to clk_sys
// Notes: Nonvolatile behaviour modelled as flops with reset values
`timescale 1ns/1ps
module msp_lock #(
	parameter int FL_SECTORS = 8,
	parameter int EE_SECTORS = 4,
	parameter logic [7:0] FL_LOCK_INIT = 8'h00,
	parameter logic [3:0] EE_LOCK_INIT = 4'h0
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic prog_we,
	input wire logic [FL_SECTORS-1:0] prog_fl_lock,
	input wire logic [EE_SECTORS-1:0] prog_ee_lock,
	input wire logic prog_security_set,
	output logic [FL_SECTORS-1:0] fl_lock,
	output logic [EE_SECTORS-1:0] ee_lock,
	output logic security
);
	import msp_pkg::*;
	logic [FL_SECTORS-1:0] fl_q, fl_d;
	logic [EE_SECTORS-1:0] ee_q, ee_d;
	logic sec_q, sec_d;
	always_comb
	begin
		fl_d = fl_q;
		ee_d = ee_q;
		sec_d = sec_q | prog_security_set;
		if (prog_we)
		begin
			fl_d = prog_fl_lock;
			ee_d = prog_ee_lock;
		end
	end
	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			fl_q <= FL_LOCK_INIT[FL_SECTORS-1:0];
			ee_q <= EE_LOCK_INIT[EE_SECTORS-1:0];
			sec_q <= 1'b0;
		end
		else
		begin
			fl_q <= fl_d;
			ee_q <= ee_d;
			sec_q <= sec_d;
		end
	end
	assign fl_lock = fl_q;
	assign ee_lock = ee_q;
	assign security = sec_q;
endmodule

// ### core/msp_pkg.sv
// Purpose: Constants for the memory select, paging and protection block
// Assumes: 8-bit data bus, config register space offsets relative to its base
// Notes: Offsets are byte offsets inside the config register space
// How it works
// - One lock flag per flash and eeprom sector blocks program and erase.
// - Lock flags change only through the test or programmer port.
// - Bus reads return lock flags; bus writes to them do nothing.
// - Program or erase aimed at a locked sector is dropped silently.
// - Verify on a locked sector acts as a plain read.
// - Reset command, one or three writes, returns memory engine to idle read.
// - Flash lock status bit i is 1 when flash sector i is locked.
// - Eeprom status bits 3..0 are locks, 6..4 zero, 7 security bit.
// - 2K by 8 sram is enabled only while its select is high.
// - Eeprom select beats flash select on the same address.
// - Sram or io select beats any flash or eeprom select.
// - Strobe map chooses fetch strobe, read strobe or both for flash and eeprom; sram always takes read, fetch optional.
// - Strobe map loads its initial value at reset, rewritable anytime.
// - Strobe map 0ch gives separate code and data spaces.
// - Strobe map bits 2 and 4 set put flash in combined space.
// - Eight-bit page register, read and written on data bits 7..0, feeds decoder.
// - Page register sits at offset e0h of the config register space.
package msp_pkg;
	localparam logic [7:0] OFS_PAGE = 8'he0;
	localparam logic [7:0] OFS_STROBE_MAP = 8'hc2;
	localparam logic [7:0] OFS_FLASH_LOCK = 8'hc0;
	localparam logic [7:0] OFS_EE_LOCK = 8'hc1;
	localparam logic [7:0] PAGE_RST = 8'h00;
	localparam logic [7:0] MAP_RST = 8'h0c;
	localparam int MAP_SRAM_FETCH = 0;
	localparam int MAP_EE_FETCH = 1;
	localparam int MAP_FL_FETCH = 2;
	localparam int MAP_EE_READ = 3;
	localparam int MAP_FL_READ = 4;
	localparam int MAP_PERIPHERAL_IO_ENABLE = 7;
	localparam int EE_SECURITY_BIT = 7;
	localparam logic [7:0] CMD_RESET = 8'hf0;
	localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
	localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
	localparam logic [7:0] CMD_PROGRAM = 8'ha0;
	localparam logic [7:0] CMD_ERASE = 8'h80;
	localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
	localparam real RESET_TIME_MS = 1.0;
	localparam real CLK_NS = 100.0;
	localparam int RESET_CYCLES = int'(RESET_TIME_MS * 1.0e6 / CLK_NS);
	typedef enum logic [1:0] {MSP_SEL_NONE, MSP_SEL_IO, MSP_SEL_EE, MSP_SEL_FL} msp_sel_e;
	typedef enum {MSP_IDLE, MSP_UNL1, MSP_UNL2, MSP_ERASE_UNL0, MSP_ERASE_UNL1,
		MSP_ERASE_UNL2, MSP_PROG_DATA, MSP_RECOVER} msp_state_e;
endpackage

// ### core/msp_top.sv
// Purpose: Memory select priority, strobe mapping, page register, sector locks
// Assumes: Bus strobes are one-cycle pulses synchronous to clk_sys
// Notes: Selects come from an external decoder; this block ranks and gates them
`timescale 1ns/1ps
module msp_top #(
	parameter int FL_SECTORS = 8,
	parameter int EE_SECTORS = 4,
	parameter logic [7:0] MAP_INIT = msp_pkg::MAP_RST,
	parameter int RESET_WAIT = msp_pkg::RESET_CYCLES
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [15:0] addr,
	input wire logic [7:0] wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic program_fetch_strobe,
	input wire logic config_register_space,
	input wire logic [FL_SECTORS-1:0] flash_sector_select,
	input wire logic [EE_SECTORS-1:0] eeprom_sector_select,
	input wire logic sram_select,
	input wire logic peripheral_io_select,
	input wire logic prog_we,
	input wire logic [FL_SECTORS-1:0] prog_fl_lock,
	input wire logic [EE_SECTORS-1:0] prog_ee_lock,
	input wire logic prog_security_set,
	input wire logic [7:0] mem_rdata,
	output logic [7:0] rdata,
	output logic rdata_oe,
	output logic [7:0] page_outputs,
	output logic [FL_SECTORS-1:0] fl_enable,
	output logic [EE_SECTORS-1:0] ee_enable,
	output logic sram_enable,
	output logic io_enable,
	output logic mem_program,
	output logic mem_erase,
	output logic [FL_SECTORS+EE_SECTORS-1:0] mem_sector,
	output logic [7:0] mem_wdata,
	output logic engine_busy
);
	import msp_pkg::*;

	logic [FL_SECTORS-1:0] fl_lock;
	logic [EE_SECTORS-1:0] ee_lock;
	logic security;

	msp_lock #(
		.FL_SECTORS(FL_SECTORS),
		.EE_SECTORS(EE_SECTORS)
	) u_lock (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.prog_we(prog_we),
		.prog_fl_lock(prog_fl_lock),
		.prog_ee_lock(prog_ee_lock),
		.prog_security_set(prog_security_set),
		.fl_lock(fl_lock),
		.ee_lock(ee_lock),
		.security(security)
	);

	// Register state
	logic [7:0] page_q, page_d;
	logic [7:0] map_q, map_d;
	logic [7:0] rdata_q, rdata_d;
	logic rdata_oe_q, rdata_oe_d;

	function automatic logic cfg_hit(input logic [15:0] a, input logic [7:0] ofs);
		cfg_hit = (a[7:0] == ofs);
	endfunction

	logic cfg_acc;
	assign cfg_acc = config_register_space;

	// Strobe gating and priority
	logic read_cyc;
	logic fl_ok, ee_ok, sram_ok;
	logic any_io, any_ee, any_fl;
	msp_sel_e winner;
	always_comb
	begin
		read_cyc = bus_rd | program_fetch_strobe;
		fl_ok = (bus_rd & map_q[MAP_FL_READ]) | (program_fetch_strobe & map_q[MAP_FL_FETCH]);
		ee_ok = (bus_rd & map_q[MAP_EE_READ]) | (program_fetch_strobe & map_q[MAP_EE_FETCH]);
		sram_ok = bus_rd | (program_fetch_strobe & map_q[MAP_SRAM_FETCH]);
		any_io = sram_select | config_register_space
			| (peripheral_io_select & map_q[MAP_PERIPHERAL_IO_ENABLE]);
		any_ee = |eeprom_sector_select;
		any_fl = |flash_sector_select;
		if (any_io)
			winner = MSP_SEL_IO;
		else if (any_ee)
			winner = MSP_SEL_EE;
		else if (any_fl)
			winner = MSP_SEL_FL;
		else
			winner = MSP_SEL_NONE;
	end

	logic [FL_SECTORS-1:0] fl_en_q, fl_en_d;
	logic [EE_SECTORS-1:0] ee_en_q, ee_en_d;
	logic sram_en_q, sram_en_d;
	logic io_en_q, io_en_d;
	always_comb
	begin
		fl_en_d = '0;
		ee_en_d = '0;
		sram_en_d = 1'b0;
		io_en_d = 1'b0;
		case (winner)
			MSP_SEL_IO:
			begin
				sram_en_d = sram_select & sram_ok & read_cyc;
				io_en_d = peripheral_io_select & map_q[MAP_PERIPHERAL_IO_ENABLE] & ~sram_select;
			end
			MSP_SEL_EE: ee_en_d = eeprom_sector_select & {EE_SECTORS{ee_ok | bus_wr}};
			MSP_SEL_FL: fl_en_d = flash_sector_select & {FL_SECTORS{fl_ok | bus_wr}};
			default: ;
		endcase
		if (winner == MSP_SEL_IO && sram_select && bus_wr)
			sram_en_d = 1'b1;
	end

	// Register file, locks read-only
	always_comb
	begin
		page_d = page_q;
		map_d = map_q;
		rdata_d = 8'h00;
		rdata_oe_d = 1'b0;
		if (cfg_acc && bus_wr)
		begin
			if (cfg_hit(addr, OFS_PAGE))
				page_d = wdata;
			if (cfg_hit(addr, OFS_STROBE_MAP))
				map_d = wdata;
		end
		if (cfg_acc && bus_rd)
		begin
			rdata_oe_d = 1'b1;
			if (cfg_hit(addr, OFS_PAGE))
				rdata_d = page_q;
			else if (cfg_hit(addr, OFS_STROBE_MAP))
				rdata_d = map_q;
			else if (cfg_hit(addr, OFS_FLASH_LOCK))
				rdata_d = 8'(fl_lock);
			else if (cfg_hit(addr, OFS_EE_LOCK))
			begin
				rdata_d = 8'(ee_lock);
				rdata_d[EE_SECURITY_BIT] = security;
			end
		end
		else if (read_cyc && winner != MSP_SEL_NONE && !cfg_acc)
		begin
			rdata_oe_d = (|fl_en_d) | (|ee_en_d) | sram_en_d | io_en_d;
			rdata_d = rdata_oe_d ? mem_rdata : 8'h00;
		end
	end

	// Command sequencer for program, erase and reset
	msp_state_e st_q, st_d;
	logic [$clog2(RESET_WAIT+1)-1:0] cnt_q, cnt_d;
	logic prog_q, prog_d, erase_q, erase_d;
	logic [FL_SECTORS+EE_SECTORS-1:0] sec_q, sec_d;
	logic [7:0] mwd_q, mwd_d;
	logic busy_q, busy_d;
	logic mem_wr;
	logic [FL_SECTORS+EE_SECTORS-1:0] tgt, tgt_locked;
	always_comb
	begin
		mem_wr = bus_wr & ~cfg_acc & (winner == MSP_SEL_EE || winner == MSP_SEL_FL);
		tgt = {ee_en_d, fl_en_d};
		tgt_locked = tgt & {ee_lock, fl_lock};
		st_d = st_q;
		cnt_d = cnt_q;
		prog_d = 1'b0;
		erase_d = 1'b0;
		sec_d = sec_q;
		mwd_d = mwd_q;
		if (mem_wr && wdata == CMD_RESET && st_q != MSP_RECOVER)
		begin
			st_d = MSP_RECOVER;
			cnt_d = '0;
		end
		else
		begin
			case (st_q)
				MSP_IDLE:
					if (mem_wr && wdata == CMD_UNLOCK1)
						st_d = MSP_UNL1;
				MSP_UNL1:
					if (mem_wr)
						st_d = (wdata == CMD_UNLOCK2) ? MSP_UNL2 : MSP_IDLE;
				MSP_UNL2:
					if (mem_wr)
					begin
						if (wdata == CMD_PROGRAM)
							st_d = MSP_PROG_DATA;
						else if (wdata == CMD_ERASE)
							st_d = MSP_ERASE_UNL0;
						else
							st_d = MSP_IDLE;
					end
				MSP_ERASE_UNL0:
					if (mem_wr)
						st_d = (wdata == CMD_UNLOCK1) ? MSP_ERASE_UNL1 : MSP_IDLE;
				MSP_ERASE_UNL1:
					if (mem_wr)
						st_d = (wdata == CMD_UNLOCK2) ? MSP_ERASE_UNL2 : MSP_IDLE;
				MSP_ERASE_UNL2:
					if (mem_wr)
					begin
						st_d = MSP_IDLE;
						if (wdata == CMD_SECTOR_ERASE && tgt_locked == '0)
						begin
							erase_d = 1'b1;
							sec_d = tgt;
						end
					end
				MSP_PROG_DATA:
					if (mem_wr)
					begin
						st_d = MSP_IDLE;
						if (tgt_locked == '0)
						begin
							prog_d = 1'b1;
							sec_d = tgt;
							mwd_d = wdata;
						end
					end
				MSP_RECOVER:
				begin
					cnt_d = cnt_q + 1'b1;
					if (cnt_q >= ($bits(cnt_q))'(RESET_WAIT - 1))
						st_d = MSP_IDLE;
				end
				default: st_d = MSP_IDLE;
			endcase
		end
		busy_d = (st_d == MSP_RECOVER);
	end

	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			page_q <= PAGE_RST;
			map_q <= MAP_INIT;
			rdata_q <= 8'h00;
			rdata_oe_q <= 1'b0;
			fl_en_q <= '0;
			ee_en_q <= '0;
			sram_en_q <= 1'b0;
			io_en_q <= 1'b0;
			st_q <= MSP_IDLE;
			cnt_q <= '0;
			prog_q <= 1'b0;
			erase_q <= 1'b0;
			sec_q <= '0;
			mwd_q <= 8'h00;
			busy_q <= 1'b0;
		end
		else
		begin
			page_q <= page_d;
			map_q <= map_d;
			rdata_q <= rdata_d;
			rdata_oe_q <= rdata_oe_d;
			fl_en_q <= fl_en_d;
			ee_en_q <= ee_en_d;
			sram_en_q <= sram_en_d;
			io_en_q <= io_en_d;
			st_q <= st_d;
			cnt_q <= cnt_d;
			prog_q <= prog_d;
			erase_q <= erase_d;
			sec_q <= sec_d;
			mwd_q <= mwd_d;
			busy_q <= busy_d;
		end
	end

	assign rdata = rdata_q;
	assign rdata_oe = rdata_oe_q;
	assign page_outputs = page_q;
	assign fl_enable = fl_en_q;
	assign ee_enable = ee_en_q;
	assign sram_enable = sram_en_q;
	assign io_enable = io_en_q;
	assign mem_program = prog_q;
	assign mem_erase = erase_q;
	assign mem_sector = sec_q;
	assign mem_wdata = mwd_q;
	assign engine_busy = busy_q;
endmodule

// ### tb/msp_mcu_model.sv
// Purpose: Microcontroller bus model issuing single strobe cycles
// Assumes: Strobes are taken on the rising clock edge
// Notes: Released address and data lines show inverted values
`timescale 1ns/1ps
module msp_mcu_model (
	input wire logic clk_sys,
	output logic [15:0] addr,
	output logic [7:0] wdata,
	output logic bus_wr,
	output logic bus_rd,
	output logic program_fetch_strobe
);
	initial
	begin
		addr = 16'h0000;
		wdata = 8'h00;
		{bus_wr, bus_rd, program_fetch_strobe} = 3'b000;
	end
	// One strobe cycle, k is {write, read, fetch}
	task automatic cyc(input logic [2:0] k, input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		#1;
		addr = a;
		wdata = d;
		{bus_wr, bus_rd, program_fetch_strobe} = k;
		@(posedge clk_sys);
		#1;
		{bus_wr, bus_rd, program_fetch_strobe} = 3'b000;
		addr = ~a;
		wdata = ~d;
	endtask
endmodule

// ### tb/msp_top_asserts.sv
// Purpose: Port checks for the memory select block
// Assumes: One clock domain, sync reset
// Notes: Bound to msp_top from the testbench file
`timescale 1ns/1ps
module msp_top_asserts
	import msp_pkg::*;
#(
	parameter int FL_SECTORS = 8,
	parameter int EE_SECTORS = 4,
	parameter int RESET_WAIT = 5
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [15:0] addr,
	input wire logic [7:0] wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic program_fetch_strobe,
	input wire logic config_register_space,
	input wire logic [FL_SECTORS-1:0] flash_sector_select,
	input wire logic [EE_SECTORS-1:0] eeprom_sector_select,
	input wire logic sram_select,
	input wire logic peripheral_io_select,
	input wire logic [7:0] rdata,
	input wire logic rdata_oe,
	input wire logic [7:0] page_outputs,
	input wire logic [FL_SECTORS-1:0] fl_enable,
	input wire logic [EE_SECTORS-1:0] ee_enable,
	input wire logic sram_enable,
	input wire logic mem_program,
	input wire logic engine_busy
);
	logic [15:0] busy_n_q, busy_n_d;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	always_comb busy_n_d = engine_busy ? busy_n_q + 16'h0001 : 16'h0000;
	always_ff @(posedge clk_sys) busy_n_q <= nrst ? busy_n_d : 16'h0000;
	a_page_readback: assert property (config_register_space && bus_rd && addr[7:0] == OFS_PAGE
		|=> rdata_oe && rdata == page_outputs) else $error("page read mismatch");
	a_page_write: assert property (config_register_space && bus_wr && addr[7:0] == OFS_PAGE
		|=> page_outputs == $past(wdata)) else $error("page write lost");
	a_idle_quiet: assert property ((bus_rd || program_fetch_strobe) && !config_register_space
		&& flash_sector_select == '0 && eeprom_sector_select == '0 && !sram_select
		&& !peripheral_io_select |=> !rdata_oe) else $error("bus driven with no select");
	a_ee_over_fl: assert property (|ee_enable |-> fl_enable == '0
		&& $past(|eeprom_sector_select)) else $error("flash beside eeprom");
	a_sram_wins: assert property (bus_rd && sram_select && !config_register_space
		&& !peripheral_io_select |=> sram_enable && ee_enable == '0 && fl_enable == '0)
		else $error("sram lost priority");
	a_sram_needs_sel: assert property (sram_enable |-> $past(sram_select))
		else $error("sram enabled unselected");
	a_prog_cause: assert property (mem_program |-> $past(bus_wr) || $past(bus_wr, 2))
		else $error("program without write");
	a_busy_bound: assert property (busy_n_q <= RESET_WAIT + 1)
		else $error("reset recovery too long");
	a_reset_clear: assert property (@(posedge clk_sys) disable iff (1'b0) !nrst
		|=> page_outputs == 8'h00 && !rdata_oe && !engine_busy)
		else $error("state not cleared by reset");
	c_page_read: cover property (config_register_space && bus_rd && addr[7:0] == OFS_PAGE);
	c_sram_hit: cover property (sram_enable);
	c_busy: cover property ($rose(engine_busy));
	c_program: cover property (mem_program);
endmodule

// ### tb/testbench.sv
// Purpose: Self-checking bench for the memory select block
// Assumes: Bus model issues one strobe at a time
// Notes: Fixed seed, short reset recovery count
`timescale 1ns/1ps
`define CHK(n, e, g) \
begin \
	checks_done++; \
	if ((g) !== (e)) \
	begin \
		$display("unexpected %s exp %h got %h", n, e, g); \
		miscompares++; \
	end \
end
module testbench;
	import msp_pkg::*;
	localparam int RW = 5;
	localparam logic [19:0] PRI = 20'h01937;
	logic clk_sys = 1'b0, nrst = 1'b0, config_register_space = 1'b0, sram_select = 1'b0;
	logic peripheral_io_select = 1'b0, prog_we = 1'b0, prog_security_set = 1'b0;
	logic [7:0] flash_sector_select = 8'h00, prog_fl_lock = 8'h00, mem_rdata = 8'h00;
	logic [3:0] eeprom_sector_select = 4'h0, prog_ee_lock = 4'h0;
	logic [15:0] addr;
	logic [7:0] wdata, rdata, page_outputs, fl_enable, v, lf;
	logic [3:0] ee_enable, le, e;
	logic bus_wr, bus_rd, program_fetch_strobe, rdata_oe, sram_enable, io_enable;
	logic mem_program, mem_erase, engine_busy;
	logic [11:0] mem_sector, sec_seen = 12'h000;
	logic [7:0] mem_wdata, wd_seen = 8'h00;
	int miscompares = 0, checks_done = 0, seed, prog_n = 0, erase_n = 0, t;
	always #50 clk_sys = ~clk_sys;
	always @(posedge clk_sys)
	begin
		prog_n += mem_program;
		erase_n += mem_erase;
		if (mem_program)
		begin
			sec_seen = mem_sector;
			wd_seen = mem_wdata;
		end
	end
	msp_top #(.RESET_WAIT(RW)) dut_u (.clk_sys, .nrst, .addr, .wdata, .bus_wr, .bus_rd,
		.program_fetch_strobe, .config_register_space, .flash_sector_select,
		.eeprom_sector_select, .sram_select, .peripheral_io_select, .prog_we, .prog_fl_lock,
		.prog_ee_lock, .prog_security_set, .mem_rdata, .rdata, .rdata_oe, .page_outputs,
		.fl_enable, .ee_enable, .sram_enable, .io_enable, .mem_program, .mem_erase,
		.mem_sector, .mem_wdata, .engine_busy);
	msp_mcu_model mcu_u (.clk_sys, .addr, .wdata, .bus_wr, .bus_rd, .program_fetch_strobe);
	function automatic logic [3:0] gate(logic [7:0] m, logic f, int k);
		logic [3:0] g;
		g = f ? {1'b0, m[0], m[1], m[2]} : {2'b01, m[3], m[4]};
		return g & (4'b0001 << k);
	endfunction
	function automatic logic [3:0] win(logic [3:0] s);
		for (int b = 3; b >= 0; b--)
			if (s[b])
				return 4'b0001 << b;
		return 4'b0000;
	endfunction
	task automatic reg_rd(input logic [7:0] o, input logic [7:0] x, input string n);
		config_register_space = 1'b1;
		mcu_u.cyc(3'b010, {8'h00, o}, 8'h00);
		`CHK(n, x, rdata)
		`CHK("oe", 1'b1, rdata_oe)
	endtask
	task automatic reg_wr(input logic [7:0] o, input logic [7:0] d);
		config_register_space = 1'b1;
		mcu_u.cyc(3'b100, {8'h00, o}, d);
	endtask
	task automatic cmd(input logic [47:0] s, input int n);
		config_register_space = 1'b0;
		for (int i = n - 1; i >= 0; i--)
			mcu_u.cyc(3'b100, 16'h8000, s[i*8 +: 8]);
	endtask
	// Memory access, enables {io, sram, ee, flash} compared with x
	task automatic acc(input logic f, input logic [3:0] x);
		config_register_space = 1'b0;
		mem_rdata = $random(seed);
		mcu_u.cyc(f ? 3'b001 : 3'b010, 16'h8000, 8'h00);
		`CHK("en", x, {io_enable, sram_enable, |ee_enable, |fl_enable})
		`CHK("oe", |x, rdata_oe)
		if (|x)
			`CHK("data", mem_rdata, rdata)
	endtask
	task automatic pass_clk(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task results;
		if (miscompares == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		seed = 98867;
		pass_clk(10);
		nrst = 1'b1;
		reg_rd(OFS_STROBE_MAP, MAP_RST, "map");
		for (int i = 0; i < 8; i++)
		begin
			v = (i == 0) ? 8'hff : $random(seed);
			reg_wr(OFS_PAGE, v);
			`CHK("page_out", v, page_outputs)
			reg_rd(OFS_PAGE, v, "page");
		end
		lf = ($random(seed) | 8'h01) & 8'hfd;
		le = $random(seed);
		{prog_we, prog_security_set, prog_fl_lock, prog_ee_lock} = {2'b11, lf, le};
		pass_clk(1);
		{prog_we, prog_security_set, prog_fl_lock, prog_ee_lock} = {2'b00, ~lf, ~le};
		reg_wr(OFS_FLASH_LOCK, ~lf);
		reg_wr(OFS_EE_LOCK, 8'h00);
		reg_rd(OFS_FLASH_LOCK, lf, "fl_lock");
		reg_rd(OFS_EE_LOCK, {1'b1, 3'b000, le}, "ee_lock");
		for (int s = 0; s < 2; s++)
		begin
			flash_sector_select = 8'h01 << s;
			cmd({16'h0000, 24'haa55a0, 8'h5a}, 4);
			cmd(48'haa5580aa5530, 6);
		end
		pass_clk(2);
		`CHK("programs", 1, prog_n)
		`CHK("erases", 1, erase_n)
		`CHK("sector", 12'h002, sec_seen)
		`CHK("wdata", 8'h5a, wd_seen)
		for (int n = 1; n <= 3; n += 2)
		begin
			cmd(48'haa55f0, n);
			`CHK("busy", 1'b1, engine_busy)
			for (t = 0; engine_busy === 1'b1 && t < RW + 3; t++)
				pass_clk(1);
			`CHK("idle", 1'b0, engine_busy)
		end
		cmd({16'h0000, 24'haa55a0, 8'h3c}, 4);
		pass_clk(2);
		`CHK("programs", 2, prog_n)
		`CHK("wdata", 8'h3c, wd_seen)
		for (int i = 0; i < 8; i++)
		begin
			v = (i == 0) ? 8'h0c : (i == 1) ? 8'h14 : $random(seed) & 8'h1f;
			reg_wr(OFS_STROBE_MAP, v);
			reg_rd(OFS_STROBE_MAP, v, "map");
			for (int k = 0; k < 6; k++)
			begin
				// Only one select at a time, so same-level spaces never overlap
				sram_select = (k % 3 == 2);
				eeprom_sector_select = (k % 3 == 1) ? 4'h1 << (i % 4) : 4'h0;
				flash_sector_select = (k % 3 == 0) ? 8'h01 << i : 8'h00;
				acc(k >= 3, gate(v, k >= 3, k % 3));
			end
		end
		reg_wr(OFS_STROBE_MAP, 8'h9f);
		for (int j = 0; j < 5; j++)
		begin
			e = PRI[4*j +: 4];
			{peripheral_io_select, sram_select} = e[3:2];
			eeprom_sector_select = {3'b000, e[1]};
			flash_sector_select = {7'h00, e[0]};
			acc(1'b0, win(e));
		end
		nrst = 1'b0;
		pass_clk(2);
		nrst = 1'b1;
		reg_rd(OFS_STROBE_MAP, MAP_RST, "map");
		reg_rd(OFS_PAGE, PAGE_RST, "page");
		results();
	end
	initial
	begin
		#(3000 * 100);
		miscompares++;
		results();
	end
endmodule
bind msp_top msp_top_asserts #(.FL_SECTORS(FL_SECTORS), .EE_SECTORS(EE_SECTORS),
	.RESET_WAIT(RESET_WAIT)) chk_u (.clk_sys, .nrst, .addr, .wdata, .bus_wr, .bus_rd,
	.program_fetch_strobe, .config_register_space, .flash_sector_select,
	.eeprom_sector_select, .sram_select, .peripheral_io_select, .rdata, .rdata_oe,
	.page_outputs, .fl_enable, .ee_enable, .sram_enable, .mem_program, .engine_busy);
